// >>> dv/config_master_model.sv
`timescale 1ns/100ps
module config_master_model (
  // Clock
  input wire logic clk,
  // Slave-side pins
  output logic hard_reset_n,
  output logic strobe_n,
  output logic [7:0] data
);
  initial begin
    hard_reset_n = 1'b1;
    strobe_n = 1'b1;
    data = 8'h00;
  end
  //////////////////////////////////////////////////////////
  // Kept first among slaves, wide option only as central
  // resource
  task automatic load(input logic [7:0] w, input bit hard, input bit strb);
    @(posedge clk);
    hard_reset_n <= !hard;
    repeat (4) @(posedge clk);
    strobe_n <= !strb;
    data <= w;
    repeat (6) @(posedge clk);
    strobe_n <= 1'b1; // Word held past the strobe edge
    repeat (6) @(posedge clk);
    hard_reset_n <= 1'b1;
    data <= ~w; // Stale word must not look valid
  endtask : load
endmodule : config_master_model

// >>> dv/poc_asserts.sv
`timescale 1ns/100ps
module poc_asserts #(
  parameter int unsigned lock_cycles = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins
  input wire logic power_on_reset_n,
  input wire logic board_ok_n,
  input wire logic reset_config_strobe_n,
  input wire logic psel,
  input wire logic penable,
  // Outputs
  input wire logic pready,
  input wire logic boot_from_pci,
  input wire logic pll_skip_on,
  input wire logic [2:0] pll_high_range,
  input wire logic pll_reset,
  input wire logic pll_locked,
  input wire logic core_reset_n,
  input wire logic bus_reset_release,
  input wire logic pci_a_wide_on,
  input wire logic pci_a_wide_request_n_oe,
  input wire logic [5:1] irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Pin syncs add two cycles, hence the slack
  a_pll_por_held: assert property (
    $fell(power_on_reset_n) |-> ##[1:5] pll_reset)
    else $error("pll not held in power reset");
  a_pll_board: assert property (
    $rose(board_ok_n) |-> ##[1:5] pll_reset)
    else $error("pll not held on board fault");
  a_lock_delay: assert property (
    $rose(pll_locked) |-> !$past(pll_reset, lock_cycles - 2))
    else $error("lock too early");
  a_core_gated: assert property (
    !pll_locked |-> !core_reset_n)
    else $error("core released before lock");
  a_bus_after_lock: assert property (
    bus_reset_release |-> pll_locked && !pll_reset)
    else $error("bus reset released before lock");
  a_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_cause: assert property (
    pready |-> $past(psel) && $past(penable))
    else $error("ready without access");
  a_wide_gated: assert property (
    pci_a_wide_request_n_oe |-> pci_a_wide_on && pll_locked)
    else $error("wide request without option");
  a_opts_hold: assert property (
    (power_on_reset_n && !board_ok_n && reset_config_strobe_n) [*8]
    |=> $stable(boot_from_pci) && $stable(pll_skip_on))
    else $error("options moved without load");
  a_range_held: assert property (
    power_on_reset_n [*8] |=> $stable(pll_high_range))
    else $error("pll range moved");
  a_irq_window: assert property (
    !power_on_reset_n [*4] |-> irq_n == 5'h1F)
    else $error("interrupts live during straps");
endmodule : poc_asserts

bind powerup_option_capture poc_asserts #(.lock_cycles(lock_cycles))
  poc_asserts_inst (.clk(clk), .nrst(nrst),
  .power_on_reset_n(power_on_reset_n), .board_ok_n(board_ok_n),
  .reset_config_strobe_n(reset_config_strobe_n), .psel(psel),
  .penable(penable), .pready(pready), .boot_from_pci(boot_from_pci),
  .pll_skip_on(pll_skip_on), .pll_high_range(pll_high_range),
  .pll_reset(pll_reset), .pll_locked(pll_locked),
  .core_reset_n(core_reset_n), .bus_reset_release(bus_reset_release),
  .pci_a_wide_on(pci_a_wide_on),
  .pci_a_wide_request_n_oe(pci_a_wide_request_n_oe), .irq_n(irq_n));

// >>> dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk, nrst, power_on_reset_n, board_ok_n, er;
  logic pci_a_reset_n, pci_b_reset_n, cpu_clk_high_range;
  logic pci_a_high_speed, pci_b_high_speed, pll_locked;
  logic [5:1] irq_strap_n, irq_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cpu_bus_hard_reset_n, reset_config_strobe_n;
  logic [7:0] cpu_data_bus, opt;
  logic [7:0] words [2] = '{8'hA6, 8'h59};
  logic [2:0] pll_high_range;
  logic core_reset_n, bus_reset_release, wide_o, wide_oe;
  int err_count = 0;
  int samples_checked = 0;

  config_master_model config_master_model_inst (.clk,
    .hard_reset_n(cpu_bus_hard_reset_n),
    .strobe_n(reset_config_strobe_n), .data(cpu_data_bus));
  powerup_option_capture #(.lock_cycles(20)) powerup_option_capture_inst (
    .clk, .nrst, .power_on_reset_n, .board_ok_n, .cpu_bus_hard_reset_n,
    .pci_a_reset_n, .pci_b_reset_n, .cpu_clk_high_range, .pci_a_high_speed,
    .pci_b_high_speed, .irq_strap_n, .reset_config_strobe_n, .cpu_data_bus,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu_arbiter_on(opt[0]), .pci_a_arbiter_on(opt[1]),
    .pci_b_arbiter_on(opt[2]), .primary_segment(opt[3]),
    .pci_a_wide_on(opt[4]), .boot_from_pci(opt[5]),
    .alt_cpu_mode_on(opt[6]), .pll_skip_on(opt[7]), .pll_high_range,
    .pll_reset(), .pll_locked, .core_reset_n, .bus_reset_release,
    .pci_a_wide_request_n_o(wide_o), .pci_a_wide_request_n_oe(wide_oe),
    .irq_n);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  // Waits are bounded so a dead slave ends the run
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      final_report();
    end
  endtask : apb

  task automatic wait_lock();
    int n;
    n = 0;
    while (pll_locked !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (pll_locked !== 1'b1) begin
      err_count++;
      final_report();
    end
    repeat (2) @(posedge clk);
  endtask : wait_lock
  //////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    power_on_reset_n = 1'b0;
    board_ok_n = 1'b0;
    pci_a_reset_n = 1'b1;
    pci_b_reset_n = 1'b1;
    cpu_clk_high_range = 1'b1;
    pci_a_high_speed = 1'b0;
    pci_b_high_speed = 1'b1;
    irq_strap_n = 5'h15;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    power_on_reset_n <= 1'b1;
    wait_lock();
    chk(core_reset_n, 1, "core reset");
    chk(bus_reset_release, 1, "bus release");
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_1555, "strap status");
    chk(opt[3:0], 4'h5, "strap arbiters");
    chk(opt[7:4], 4'h5, "strap options");
    $display("strap capture done");
    pci_a_high_speed <= 1'b1;
    irq_strap_n <= 5'h0A;
    repeat (6) @(posedge clk);
    chk(opt, 8'h57, "live arbiter");
    chk(pll_high_range, 3'h5, "range latched");
    chk(irq_n, 5'h0A, "interrupt path");
    $display("live pins done");
    pci_a_reset_n <= 1'b0;
    pci_b_reset_n <= 1'b0;
    config_master_model_inst.load(8'hFF, 1, 0);
    chk({wide_oe, wide_o}, 2'b10, "wide request");
    pci_a_reset_n <= 1'b1;
    pci_b_reset_n <= 1'b1;
    apb(1, 12'h000, 32'hFFFF_FFFF);
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_1557, "bus resets, read only");
    apb(0, 12'h008, 0);
    chk(er, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
    $display("bus reset and refusal done");
    apb(1, 12'h004, 32'h0000_0001);
    config_master_model_inst.load(8'hFF, 0, 1);
    chk(opt, 8'h57, "strobe alone");
    foreach (words[i]) begin
      config_master_model_inst.load(words[i], 1, 1);
      cpu_clk_high_range <= !words[i][0];
      repeat (6) @(posedge clk);
      apb(0, 12'h000, 0);
      chk(rd, {19'h0, 5'h1D, words[i]}, "slave status");
      chk(opt, words[i], "slave options");
    end
    $display("slave loads done");
    board_ok_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({pll_locked, core_reset_n}, 2'b00, "fault");
    board_ok_n <= 1'b0;
    wait_lock();
    power_on_reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk(irq_n, 5'h1F, "straps masked");
    irq_strap_n <= 5'h1F;
    power_on_reset_n <= 1'b1;
    wait_lock();
    chk(opt, 8'h06, "recapture");
    chk(pll_high_range, 3'h6, "new range");
    $display("fault and power cycle done");
    final_report();
  end
endmodule : tb_top

// >>> logic/option_if.sv
`timescale 1ns/100ps
interface option_if;
  logic [7:0] opt;
  logic slave_loaded;
  logic strap_load;
  logic slave_load;
  logic [7:0] straps;
  logic [7:0] slave_word;

  modport store (
    input strap_load, slave_load, straps, slave_word,
    output opt, slave_loaded
  );
  modport ctrl (
    output strap_load, slave_load, straps, slave_word,
    input opt, slave_loaded
  );
endinterface : option_if

// >>> logic/option_pkg.sv
package option_pkg;

  // Option word layout on the cpu data bus and in the status register
  localparam int unsigned cpu_arb_bit = 0;
  localparam int unsigned pci_a_arb_bit = 1;
  localparam int unsigned pci_b_arb_bit = 2;
  localparam int unsigned primary_bit = 3;
  localparam int unsigned wide_bit = 4;
  localparam int unsigned boot_bit = 5;
  localparam int unsigned alt_mode_bit = 6;
  localparam int unsigned pll_skip_bit = 7;
  localparam int unsigned cpu_range_bit = 8;
  localparam int unsigned pci_a_range_bit = 9;
  localparam int unsigned pci_b_range_bit = 10;
  localparam int unsigned slave_loaded_bit = 11;
  localparam int unsigned lock_bit = 12;
  localparam int unsigned opt_width = 8;

  // Register map (byte addresses)
  localparam logic [11:0] status_addr = 12'h000;
  localparam logic [11:0] control_addr = 12'h004;
  localparam logic [31:0] status_reset = 32'h0000_0000;
  localparam logic [31:0] control_reset = 32'h0000_0000;

  // Timing at a 40 MHz clock
  localparam int unsigned clk_period_ps = 25000;
  localparam int unsigned strap_hold_ns = 10;
  localparam int unsigned strap_hold_cycles =
    (strap_hold_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int unsigned pll_lock_us = 100;
  localparam int unsigned pll_lock_cycles_default =
    (pll_lock_us * 1000000) / clk_period_ps;

  typedef enum logic [1:0] {
    st_reset = 2'b00,
    st_hold = 2'b01,
    st_locking = 2'b10,
    st_run = 2'b11
  } pll_state_type;

endpackage : option_pkg

// >>> logic/option_store.sv
`timescale 1ns/100ps
module option_store (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Load paths
  option_if.store port
);
  logic [7:0] opt_q;
  logic loaded_q;

  assign port.opt = opt_q;
  assign port.slave_loaded = loaded_q;

  // Slave load takes priority over strap resampling
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opt_q <= 8'h00;
    end else if (port.slave_load) begin
      opt_q <= port.slave_word; // [RULE_19]
    end else if (port.strap_load) begin
      opt_q <= port.straps;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loaded_q <= 1'b0;
    end else if (port.slave_load) begin
      loaded_q <= 1'b1;
    end
  end
endmodule : option_store

// >>> logic/powerup_option_capture.sv
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01: PLLs held in reset during power reset
// RULE_02: Resources stay reset until lock interval ends
// RULE_03: Strap sampling default, slave loading optional
// RULE_04: Slave word latched from data bus
// RULE_05: Captured options readable in status register
// RULE_06: Bus resets leave options untouched
// RULE_07: Arbiter enables follow option bits 0..2
// RULE_08: Primary segment from strap 5 or bit 3
// RULE_09: Wide request driven during pci_a reset
// RULE_10: Wide option only for central resource
// RULE_11: Boot source from strap 3 or bit 5
// RULE_12: Low strap selects alternate, incl mode
// RULE_13: PLL bypass from strap 1 or bit 7
// RULE_14: Single-PCI variant forces pci_a primary
// RULE_15: PLL ranges latched at power reset release
// RULE_16: Arbiter pins resampled until slave load
// RULE_17: Straps 5..1 latched at power release
// RULE_18: Straps become interrupts after hold window
// RULE_19: Slave load replaces strap options
// RULE_20: Master drives strobe, hard reset, data
// RULE_21: Word updated after every hard-reset sequence
// RULE_22: No wide request before word latched
// RULE_23: Master keeps device out of last four
// RULE_24: Bus resets released only after lock
// RULE_25: Data captured on strobe deassert edge
module powerup_option_capture #(
  parameter int unsigned lock_cycles = option_pkg::pll_lock_cycles_default,
  parameter bit dual_pci = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Power and reset pins
  input wire logic power_on_reset_n,
  input wire logic board_ok_n,
  input wire logic cpu_bus_hard_reset_n,
  input wire logic pci_a_reset_n,
  input wire logic pci_b_reset_n,
  // Multiplexed strap pins
  input wire logic cpu_clk_high_range,
  input wire logic pci_a_high_speed,
  input wire logic pci_b_high_speed,
  input wire logic [5:1] irq_strap_n,
  input wire logic reset_config_strobe_n,
  input wire logic [7:0] cpu_data_bus,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Option outputs
  output logic cpu_arbiter_on,
  output logic pci_a_arbiter_on,
  output logic pci_b_arbiter_on,
  output logic primary_segment,
  output logic pci_a_wide_on,
  output logic boot_from_pci,
  output logic alt_cpu_mode_on,
  output logic pll_skip_on,
  output logic [2:0] pll_high_range,
  // PLL and reset control
  output logic pll_reset,
  output logic pll_locked,
  output logic core_reset_n,
  output logic bus_reset_release,
  // Wide request pin
  output logic pci_a_wide_request_n_o,
  output logic pci_a_wide_request_n_oe,
  // Interrupt lines after strap window
  output logic [5:1] irq_n
);

  //////////////////////////////////////////////////////////////////////////
  // Synchronise the pins
  logic [13:0] raw_pins;
  logic [13:0] pins_s;
  logic por_n_s, ok_n_s, hard_n_s, pa_rst_n_s, cpu_bus_hard_reset_n_n_s;
  logic fast_s, pa_hs_s, pb_hs_s, strobe_n_s;
  logic [5:1] irq_s;
  logic [7:0] data_s;

  assign raw_pins = {power_on_reset_n, board_ok_n, cpu_bus_hard_reset_n,
    pci_a_reset_n, pci_b_reset_n, cpu_clk_high_range, pci_a_high_speed,
    pci_b_high_speed, irq_strap_n, reset_config_strobe_n};

  sync2 #(.width(14)) pin_sync (
    .clk(clk),
    .nrst(nrst),
    .d(raw_pins),
    .q(pins_s)
  );

  sync2 #(.width(8)) data_sync (
    .clk(clk),
    .nrst(nrst),
    .d(cpu_data_bus),
    .q(data_s)
  );

  assign por_n_s = pins_s[13];
  assign ok_n_s = pins_s[12];
  assign hard_n_s = pins_s[11];
  assign pa_rst_n_s = pins_s[10];
  assign cpu_bus_hard_reset_n_n_s = pins_s[9];
  assign fast_s = pins_s[8];
  assign pa_hs_s = pins_s[7];
  assign pb_hs_s = pins_s[6];
  assign irq_s = pins_s[5:1];
  assign strobe_n_s = pins_s[0];

  //////////////////////////////////////////////////////////////////////////
  // Power reset tracking and PLL lock
  logic por_n_q;
  logic strobe_n_q;
  logic strobe_armed_q;
  logic por_rise;
  logic power_fault;
  logic [31:0] count_q;
  option_pkg::pll_state_type state_q;

  // Board board_ok_n is active low; high counts as a fault
  assign power_fault = !por_n_s || ok_n_s; // [RULE_01]
  assign por_rise = por_n_s && !por_n_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      por_n_q <= 1'b0;
      strobe_n_q <= 1'b0;
    end else begin
      por_n_q <= por_n_s;
      strobe_n_q <= strobe_n_s;
    end
  end

  // The sync resets low, so a rising strobe only counts after a fall
  // was seen; this hides the false edge while the sync settles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobe_armed_q <= 1'b0;
    end else if (strobe_n_q && !strobe_n_s) begin
      strobe_armed_q <= 1'b1;
    end else if (strobe_n_s && !strobe_n_q) begin
      strobe_armed_q <= 1'b0;
    end
  end

  // Lock is a fixed count from release, not a measured lock; a slow
  // reference would need lock_cycles raised to match
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= option_pkg::st_reset;
      count_q <= 32'h0000_0000;
    end else if (power_fault) begin
      state_q <= option_pkg::st_reset; // [RULE_01]
      count_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        option_pkg::st_reset: begin
          state_q <= option_pkg::st_hold;
          count_q <= 32'h0000_0000;
        end
        option_pkg::st_hold: begin
          count_q <= count_q + 32'h0000_0001;
          if (count_q + 32'h0000_0001 >= 32'(option_pkg::strap_hold_cycles))
          begin
            state_q <= option_pkg::st_locking;
            count_q <= 32'h0000_0000;
          end
        end
        option_pkg::st_locking: begin
          count_q <= count_q + 32'h0000_0001;
          if (count_q + 32'h0000_0001 >= 32'(lock_cycles)) begin
            state_q <= option_pkg::st_run; // [RULE_02]
          end
        end
        option_pkg::st_run: begin
          state_q <= option_pkg::st_run;
        end
        default: begin
          state_q <= option_pkg::st_reset;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Option capture paths
  option_if opt_bus ();
  logic [2:0] range_q;
  logic slave_en_q;
  logic in_window;
  logic [7:0] strap_word;

  // Low strap picks the alternate option
  assign strap_word = {~irq_s[1], ~irq_s[2], ~irq_s[3], ~irq_s[4],
    ~irq_s[5], pb_hs_s, pa_hs_s, fast_s}; // [RULE_12]
  assign in_window = state_q == option_pkg::st_hold;
  assign opt_bus.straps = por_rise ? strap_word :
    {opt_bus.opt[7:3], pb_hs_s, pa_hs_s, fast_s};
  // Straps on the rising edge; arbiter bits follow pins until a slave load
  assign opt_bus.strap_load = por_rise ||
    (por_n_s && !opt_bus.slave_loaded); // [RULE_16] [RULE_17] [RULE_03]
  // Strobe rising while hard reset low, outside power reset; only nrst clears slave_loaded
  assign opt_bus.slave_load = slave_en_q && strobe_armed_q &&
    strobe_n_s && !strobe_n_q && !hard_n_s &&
    por_n_s; // [RULE_04] [RULE_25] [RULE_21] [RULE_06]
  assign opt_bus.slave_word = data_s;

  option_store store (
    .clk(clk),
    .nrst(nrst),
    .port(opt_bus)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      range_q <= 3'b000;
    end else if (por_rise) begin
      range_q <= {pb_hs_s, pa_hs_s, fast_s}; // [RULE_15]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [31:0] status_word;
  logic wr_ctrl;
  logic addr_hit;

  assign status_word = {19'h0_0000, state_q == option_pkg::st_run,
    opt_bus.slave_loaded, range_q, opt_bus.opt}; // [RULE_05]
  assign addr_hit = paddr == option_pkg::status_addr ||
    paddr == option_pkg::control_addr;
  // Writes land only at the edge that completes the access
  assign wr_ctrl = psel && penable && pready && pwrite &&
    paddr == option_pkg::control_addr;

  // Control bit 0 arms configuration-slave loading
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slave_en_q <= option_pkg::control_reset[0];
    end else if (wr_ctrl) begin
      slave_en_q <= pwdata[0];
    end
  end

  // One wait state keeps read data registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !addr_hit;
      case (paddr)
        option_pkg::status_addr: prdata <= status_word;
        option_pkg::control_addr: prdata <= {31'h0000_0000, slave_en_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  logic run;
  assign run = state_q == option_pkg::st_run;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_arbiter_on <= 1'b0;
      pci_a_arbiter_on <= 1'b0;
      pci_b_arbiter_on <= 1'b0;
      primary_segment <= 1'b0;
      pci_a_wide_on <= 1'b0;
      boot_from_pci <= 1'b0;
      alt_cpu_mode_on <= 1'b0;
      pll_skip_on <= 1'b0;
      pll_high_range <= 3'b000;
    end else begin
      cpu_arbiter_on <= opt_bus.opt[option_pkg::cpu_arb_bit]; // [RULE_07]
      pci_a_arbiter_on <= opt_bus.opt[option_pkg::pci_a_arb_bit];
      pci_b_arbiter_on <= dual_pci &&
        opt_bus.opt[option_pkg::pci_b_arb_bit]; // [RULE_14]
      primary_segment <= dual_pci &&
        opt_bus.opt[option_pkg::primary_bit]; // [RULE_08] [RULE_14]
      pci_a_wide_on <= opt_bus.opt[option_pkg::wide_bit];
      boot_from_pci <= opt_bus.opt[option_pkg::boot_bit]; // [RULE_11]
      alt_cpu_mode_on <= opt_bus.opt[option_pkg::alt_mode_bit];
      pll_skip_on <= opt_bus.opt[option_pkg::pll_skip_bit]; // [RULE_13]
      pll_high_range <= range_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_reset <= 1'b1;
      pll_locked <= 1'b0;
      core_reset_n <= 1'b0;
      bus_reset_release <= 1'b0;
    end else begin
      pll_reset <= state_q == option_pkg::st_reset; // [RULE_01]
      pll_locked <= run;
      core_reset_n <= run; // [RULE_02]
      bus_reset_release <= run; // [RULE_24]
    end
  end

  // Width advert only during pci_a reset, only once the word is final
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pci_a_wide_request_n_o <= 1'b1;
      pci_a_wide_request_n_oe <= 1'b0;
    end else begin
      pci_a_wide_request_n_o <= 1'b0;
      pci_a_wide_request_n_oe <= opt_bus.opt[option_pkg::wide_bit] &&
        !pa_rst_n_s && run &&
        (!slave_en_q || opt_bus.slave_loaded); // [RULE_09] [RULE_22]
    end
  end

  // Interrupt lines idle high inside the strap window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_n <= 5'h1F;
    end else if (!por_n_s || in_window) begin
      irq_n <= 5'h1F;
    end else begin
      irq_n <= irq_s; // [RULE_18]
    end
  end

  // Second bus reset only gates nothing here; kept for symmetry
  logic unused_cpu_bus_hard_reset_n;
  assign unused_cpu_bus_hard_reset_n = cpu_bus_hard_reset_n_n_s;

endmodule : powerup_option_capture

// >>> logic/sync2.sv
`timescale 1ns/100ps
module sync2 #(
  parameter int unsigned width = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Data
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] meta_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sync2
